// [scat_pkg.sv]
// Constants shared by the scroll-area and tear-control command logic.
package scat_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
  localparam logic [7:0] CMD_PARTIAL_DISPLAY = 8'h12;
  localparam logic [7:0] CMD_NORMAL_DISPLAY = 8'h13;
  localparam logic [7:0] CMD_SCROLL_REGION_DEFINE = 8'h33;
  localparam logic [7:0] CMD_TEAR_SIGNAL_DISABLE = 8'h34;
  localparam logic [7:0] CMD_TEAR_SIGNAL_ENABLE = 8'h35;
  localparam logic [7:0] CMD_SCROLL_START = 8'h37;

  // ==========================================================================
  // Layout values
  localparam int LINE_BITS = 9;
  localparam logic [2:0] SCROLL_PARAM_LAST = 3'h5;
  localparam logic [15:0] TOP_FIXED_RESET = 16'h0000;
  localparam logic [15:0] SCROLL_AREA_RESET = 16'h01e0;
  localparam logic [15:0] BOTTOM_FIXED_RESET = 16'h0000;
  localparam logic [39:0] SHADOW_RESET = 40'h00_0000_0000;

  // ==========================================================================
  // Interpreter states
  typedef enum logic [0:0] {
    SCAT_IDLE = 1'b0,
    SCAT_PARAM = 1'b1
  } scat_state_t;

endpackage : scat_pkg

// [scat_bus_if.sv]
// Byte events passed from the bus capture stage to the command interpreter.
`timescale 1ns/1ns
`default_nettype none
interface scat_bus_if;
  logic byte_valid;
  logic is_param;
  logic [7:0] data;
  modport capture (output byte_valid, output is_param, output data);
  modport interp (input byte_valid, input is_param, input data);
endinterface : scat_bus_if
`default_nettype wire

// [scat_capture.sv]
// Synchronises the host command bus pins and emits one event per written byte.
`timescale 1ns/1ns
`default_nettype none
module scat_capture (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_write_strobe_n,
  input wire logic i_cmd_param_select,
  input wire logic [7:0] i_data,
  scat_bus_if.capture bus
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic select_meta;
    logic select_sync;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    logic valid;
    logic is_param;
    logic [7:0] data;
  } scat_cap_t;

  scat_cap_t cap_r;
  scat_cap_t cap_nxt;

  // ==========================================================================
  // Capture
  // Data and select ride the same two-stage path as the strobe, so they line up
  // with the detected edge as long as the host holds them a few cycles after it.
  always_comb begin
    cap_nxt = cap_r;
    cap_nxt.strobe_meta = i_write_strobe_n;
    cap_nxt.strobe_sync = cap_r.strobe_meta;
    cap_nxt.strobe_prev = cap_r.strobe_sync;
    cap_nxt.select_meta = i_cmd_param_select;
    cap_nxt.select_sync = cap_r.select_meta;
    cap_nxt.data_meta = i_data;
    cap_nxt.data_sync = cap_r.data_meta;
    cap_nxt.valid = cap_r.strobe_sync & ~cap_r.strobe_prev;
    if (cap_r.strobe_sync & ~cap_r.strobe_prev) begin
      cap_nxt.is_param = cap_r.select_sync;
      cap_nxt.data = cap_r.data_sync;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cap_r <= '{strobe_meta: 1'b1, strobe_sync: 1'b1, strobe_prev: 1'b1, select_meta: 1'b0,
                 select_sync: 1'b0, data_meta: 8'h00, data_sync: 8'h00, valid: 1'b0,
                 is_param: 1'b0, data: 8'h00};
    end else begin
      cap_r <= cap_nxt;
    end
  end

  assign bus.byte_valid = cap_r.valid;
  assign bus.is_param = cap_r.is_param;
  assign bus.data = cap_r.data;

  // ==========================================================================
  // Checks
  AST_ONE_EVENT_PER_EDGE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    cap_r.valid |=> !cap_r.valid)
    else $error("byte event lasted more than one cycle");

endmodule : scat_capture
`default_nettype wire

// [scat_ctrl.sv]
// Command interpreter for the scroll-region definition and tear-signal disable commands.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Command 33h opens a scroll-region definition that takes exactly six parameter bytes.
// - The six bytes come high byte first as top fixed, scroll area, bottom fixed; low nine bits count.
// - With vertical refresh order 0 the top fixed area counts from the memory top, bottom from its bottom.
// - With vertical refresh order 1 the top fixed area counts from the memory bottom, bottom from its top.
// - The scroll area is a height in memory lines starting right after the leading fixed area.
// - All three counts are frame-memory line pointers, not panel line positions.
// - Any reset loads top fixed 0000h, scroll area 01E0h and bottom fixed 0000h.
// - Both commands are accepted in every display, idle and sleep state.
// - Normal display on or partial display on ends scroll mode.
// - Command 34h, with no parameters, disables the tear sync output.
// - Command 34h with the tear output already off leaves the tear, scroll mode and layout state unchanged.
// - The vertical refresh order is bit 4 of the memory access control setting.
module scat_ctrl (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_write_strobe_n,
  input wire logic i_cmd_param_select,
  input wire logic [7:0] i_data,
  input wire logic i_vertical_refresh_order,
  input wire logic i_tear_timing,
  output logic [8:0] o_top_fixed_lines,
  output logic [8:0] o_scroll_area_lines,
  output logic [8:0] o_bottom_fixed_lines,
  output logic [8:0] o_scroll_first_line,
  output logic [8:0] o_scroll_last_line,
  output logic o_scroll_mode,
  output logic o_tear_enabled,
  output logic o_tear_sync_output
);

  // ==========================================================================
  // Helpers
  function automatic logic [8:0] scat_area_end(input logic [8:0] first, input logic [8:0] height);
    scat_area_end = 9'(first + height - 9'h001);
  endfunction : scat_area_end

  // ==========================================================================
  // State
  typedef struct packed {
    scat_pkg::scat_state_t state;
    logic [2:0] param_idx;
    logic [39:0] shadow;
    logic [15:0] top_fixed_lines;
    logic [15:0] scroll_area_lines;
    logic [15:0] bottom_fixed_lines;
    logic [8:0] scroll_first;
    logic [8:0] scroll_last;
    logic scroll_mode;
    logic tear_en;
    logic tear_out;
  } scat_ctrl_t;

  scat_ctrl_t s_r;
  scat_ctrl_t s_nxt;

  scat_bus_if bus ();

  scat_capture i_scat_capture (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_write_strobe_n(i_write_strobe_n),
    .i_cmd_param_select(i_cmd_param_select),
    .i_data(i_data),
    .bus(bus.capture)
  );

  logic cmd_valid;
  logic param_valid;
  logic [8:0] lead_fixed;

  assign cmd_valid = bus.byte_valid & ~bus.is_param;
  assign param_valid = bus.byte_valid & bus.is_param;

  // ==========================================================================
  // Interpreter
  // No power or display state gates the decode, so the commands work while asleep.
  always_comb begin
    s_nxt = s_r;
    if (cmd_valid) begin
      s_nxt.state = scat_pkg::SCAT_IDLE;
      unique case (bus.data)
        scat_pkg::CMD_SCROLL_REGION_DEFINE: begin
          s_nxt.state = scat_pkg::SCAT_PARAM;
          s_nxt.param_idx = 3'h0;
        end
        scat_pkg::CMD_TEAR_SIGNAL_DISABLE: begin
          if (s_r.tear_en) begin
            s_nxt.tear_en = 1'b0;
          end
        end
        scat_pkg::CMD_TEAR_SIGNAL_ENABLE: begin
          s_nxt.tear_en = 1'b1;
        end
        scat_pkg::CMD_NORMAL_DISPLAY, scat_pkg::CMD_PARTIAL_DISPLAY: begin
          s_nxt.scroll_mode = 1'b0;
        end
        scat_pkg::CMD_SCROLL_START: begin
          s_nxt.scroll_mode = 1'b1;
        end
        scat_pkg::CMD_SOFT_RESET: begin
          s_nxt.top_fixed_lines = scat_pkg::TOP_FIXED_RESET;
          s_nxt.scroll_area_lines = scat_pkg::SCROLL_AREA_RESET;
          s_nxt.bottom_fixed_lines = scat_pkg::BOTTOM_FIXED_RESET;
          s_nxt.tear_en = 1'b0;
          s_nxt.scroll_mode = 1'b0;
        end
        default: begin
          s_nxt.state = scat_pkg::SCAT_IDLE;
        end
      endcase
    end else if (param_valid && s_r.state == scat_pkg::SCAT_PARAM) begin
      s_nxt.shadow = {s_r.shadow[31:0], bus.data};
      s_nxt.param_idx = 3'(s_r.param_idx + 3'h1);
      if (s_r.param_idx == scat_pkg::SCROLL_PARAM_LAST) begin
        // A definition cut short by another command never reaches this point.
        s_nxt.top_fixed_lines = s_r.shadow[39:24];
        s_nxt.scroll_area_lines = s_r.shadow[23:8];
        s_nxt.bottom_fixed_lines = {s_r.shadow[7:0], bus.data};
        s_nxt.state = scat_pkg::SCAT_IDLE;
      end
    end
    // Fixed and scroll bounds are line pointers into frame memory.
    s_nxt.scroll_first = lead_fixed;
    s_nxt.scroll_last = scat_area_end(lead_fixed, s_r.scroll_area_lines[8:0]);
    s_nxt.tear_out = s_r.tear_en & i_tear_timing;
  end

  // With reversed refresh the bottom fixed area sits at the memory top.
  assign lead_fixed = i_vertical_refresh_order ? s_r.bottom_fixed_lines[8:0]
                                               : s_r.top_fixed_lines[8:0];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s_r <= '{state: scat_pkg::SCAT_IDLE, param_idx: 3'h0, shadow: scat_pkg::SHADOW_RESET,
               top_fixed_lines: scat_pkg::TOP_FIXED_RESET,
               scroll_area_lines: scat_pkg::SCROLL_AREA_RESET,
               bottom_fixed_lines: scat_pkg::BOTTOM_FIXED_RESET,
               scroll_first: 9'h000, scroll_last: 9'h000, scroll_mode: 1'b0,
               tear_en: 1'b0, tear_out: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_top_fixed_lines = s_r.top_fixed_lines[8:0];
  assign o_scroll_area_lines = s_r.scroll_area_lines[8:0];
  assign o_bottom_fixed_lines = s_r.bottom_fixed_lines[8:0];
  assign o_scroll_first_line = s_r.scroll_first;
  assign o_scroll_last_line = s_r.scroll_last;
  assign o_scroll_mode = s_r.scroll_mode;
  assign o_tear_enabled = s_r.tear_en;
  assign o_tear_sync_output = s_r.tear_out;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence seq_define_cmd;
    cmd_valid && bus.data == scat_pkg::CMD_SCROLL_REGION_DEFINE;
  endsequence

  sequence seq_last_param;
    param_valid && s_r.state == scat_pkg::SCAT_PARAM && s_r.param_idx == scat_pkg::SCROLL_PARAM_LAST;
  endsequence

  sequence seq_early_param;
    param_valid && s_r.state == scat_pkg::SCAT_PARAM && s_r.param_idx != scat_pkg::SCROLL_PARAM_LAST;
  endsequence

  // Any command but 33h drops intake to idle, so a late byte after an abort can never commit half a layout.
  sequence seq_stray_param;
    param_valid && s_r.state == scat_pkg::SCAT_IDLE;
  endsequence

  sequence seq_abort_cmd;
    cmd_valid && s_r.state == scat_pkg::SCAT_PARAM && bus.data != scat_pkg::CMD_SOFT_RESET;
  endsequence

  sequence seq_soft_reset_cmd;
    cmd_valid && bus.data == scat_pkg::CMD_SOFT_RESET;
  endsequence

  sequence seq_quiet_bus;
    !cmd_valid && !param_valid;
  endsequence

  AST_DEFINE_ARMS: assert property (seq_define_cmd |=>
    s_r.state == scat_pkg::SCAT_PARAM && s_r.param_idx == 3'h0)
    else $error("scroll definition command did not arm parameter intake");

  AST_LAYOUT_COMMIT: assert property (seq_last_param |=>
    s_r.top_fixed_lines == $past(s_r.shadow[39:24]) && s_r.scroll_area_lines == $past(s_r.shadow[23:8])
    && s_r.bottom_fixed_lines == {$past(s_r.shadow[7:0]), $past(bus.data)}
    && s_r.state == scat_pkg::SCAT_IDLE)
    else $error("sixth parameter did not commit the layout in order");

  AST_NO_EARLY_APPLY: assert property (seq_early_param |=>
    $stable(s_r.top_fixed_lines) && $stable(s_r.scroll_area_lines) && $stable(s_r.bottom_fixed_lines))
    else $error("layout changed before all six parameters arrived");

  AST_NORMAL_ORDER: assert property (!i_vertical_refresh_order |=>
    o_scroll_first_line == $past(s_r.top_fixed_lines[8:0]))
    else $error("normal order scroll start not after top fixed area");

  AST_REVERSED_ORDER: assert property (i_vertical_refresh_order |=>
    o_scroll_first_line == $past(s_r.bottom_fixed_lines[8:0]))
    else $error("reversed order scroll start not after bottom fixed area");

  AST_SCROLL_HEIGHT: assert property (##1 1'b1 |->
    o_scroll_last_line == 9'($past(lead_fixed) + $past(s_r.scroll_area_lines[8:0]) - 9'h001))
    else $error("scroll area end does not match its height");

  AST_RESET_DEFAULTS: assert property ($past(i_reset) |->
    s_r.top_fixed_lines == 16'h0000 && s_r.scroll_area_lines == 16'h01e0
    && s_r.bottom_fixed_lines == 16'h0000 && !s_r.tear_en)
    else $error("layout or tear state wrong after reset");

  AST_SCROLL_EXIT: assert property (cmd_valid && (bus.data == scat_pkg::CMD_NORMAL_DISPLAY
    || bus.data == scat_pkg::CMD_PARTIAL_DISPLAY) |=> !o_scroll_mode)
    else $error("scroll mode not left on display mode command");

  AST_TEAR_DISABLE: assert property (cmd_valid && bus.data == scat_pkg::CMD_TEAR_SIGNAL_DISABLE
    |=> !o_tear_enabled ##1 !o_tear_sync_output)
    else $error("tear sync output not disabled");

  AST_TEAR_OFF_IGNORED: assert property (cmd_valid && bus.data == scat_pkg::CMD_TEAR_SIGNAL_DISABLE
    && !s_r.tear_en |=> $stable(s_r.top_fixed_lines) && $stable(s_r.scroll_mode) && !s_r.tear_en)
    else $error("disable with tear output off changed state");

  // Stray and aborted bytes must leave the layout alone, or a host glitch would tear the picture.
  AST_STRAY_PARAM_IGNORED: assert property (seq_stray_param |=>
    s_r.state == scat_pkg::SCAT_IDLE && $stable(s_r.top_fixed_lines) && $stable(s_r.scroll_area_lines)
    && $stable(s_r.bottom_fixed_lines) && $stable(s_r.tear_en) && $stable(s_r.scroll_mode))
    else $error("parameter outside a definition changed state");

  AST_ABORT_KEEPS_LAYOUT: assert property (seq_abort_cmd |=>
    $stable(s_r.top_fixed_lines) && $stable(s_r.scroll_area_lines) && $stable(s_r.bottom_fixed_lines))
    else $error("aborted definition changed the layout");

  AST_DEFINE_KEEPS_LAYOUT: assert property (seq_define_cmd |=>
    $stable(s_r.top_fixed_lines) && $stable(s_r.scroll_area_lines) && $stable(s_r.bottom_fixed_lines))
    else $error("definition command changed the layout before its parameters");

  AST_OTHER_CMD_ENDS_DEFINE: assert property (cmd_valid && bus.data != scat_pkg::CMD_SCROLL_REGION_DEFINE
    |=> s_r.state == scat_pkg::SCAT_IDLE)
    else $error("command other than a definition left parameter intake armed");

  AST_IDLE_STAYS_IDLE: assert property (s_r.state == scat_pkg::SCAT_IDLE && !cmd_valid |=>
    s_r.state == scat_pkg::SCAT_IDLE)
    else $error("parameter intake armed without a definition command");

  AST_PARAM_STEP: assert property (seq_early_param |=>
    s_r.state == scat_pkg::SCAT_PARAM && s_r.param_idx == 3'($past(s_r.param_idx) + 3'h1))
    else $error("parameter count did not advance by one");

  AST_SHADOW_SHIFT: assert property (seq_early_param |=>
    s_r.shadow == {$past(s_r.shadow[31:0]), $past(bus.data)})
    else $error("parameter byte not shifted in behind the earlier ones");

  AST_SHADOW_HOLD: assert property (!param_valid |=> $stable(s_r.shadow))
    else $error("parameter shadow changed without a parameter byte");

  AST_SOFT_RESET_LAYOUT: assert property (seq_soft_reset_cmd |=>
    s_r.top_fixed_lines == 16'h0000 && s_r.scroll_area_lines == 16'h01e0 && s_r.bottom_fixed_lines == 16'h0000)
    else $error("software reset did not restore the layout defaults");

  AST_SOFT_RESET_FLAGS: assert property (seq_soft_reset_cmd |=> !o_tear_enabled && !o_scroll_mode)
    else $error("software reset left tear output or scroll mode on");

  AST_TEAR_OUT_GATED: assert property (!s_r.tear_en |=> !o_tear_sync_output)
    else $error("tear sync output active while disabled");

  AST_TEAR_FOLLOWS_TIMING: assert property (s_r.tear_en && i_tear_timing |=> o_tear_sync_output)
    else $error("tear sync output missing while enabled");

  AST_TEAR_FALL_BY_CMD: assert property ($fell(s_r.tear_en) && !$past(i_reset) |-> $past(cmd_valid))
    else $error("tear output turned off without a command");

  AST_FLAGS_HOLD_QUIET: assert property (seq_quiet_bus |=>
    $stable(s_r.scroll_mode) && $stable(s_r.tear_en) && $stable(s_r.state))
    else $error("mode or tear state changed with no byte on the bus");

  AST_LAYOUT_HOLD_QUIET: assert property (seq_quiet_bus |=>
    $stable(s_r.top_fixed_lines) && $stable(s_r.scroll_area_lines) && $stable(s_r.bottom_fixed_lines))
    else $error("layout changed with no byte on the bus");

  AST_TEAR_ENABLE_CMD: assert property (cmd_valid && bus.data == scat_pkg::CMD_TEAR_SIGNAL_ENABLE |=>
    o_tear_enabled)
    else $error("tear enable command not taken");

  AST_SCROLL_ENTER: assert property (cmd_valid && bus.data == scat_pkg::CMD_SCROLL_START |=> o_scroll_mode)
    else $error("scroll start command did not enter scroll mode");

endmodule : scat_ctrl
`default_nettype wire

// [scat_host_model.sv]
// Host processor model that writes command and parameter bytes on the display command bus.
`timescale 1ns/1ns
`default_nettype none
module scat_host_model (
  input wire logic i_core_clk,
  output logic o_write_strobe_n,
  output logic o_cmd_param_select,
  output logic [7:0] o_data
);
  // ==========================================================================
  // Bus cycles
  // Four-cycle phases leave margin over the three-cycle synchroniser window.
  localparam int PHASE = 4;

  initial begin
    o_write_strobe_n = 1'b1;
    o_cmd_param_select = 1'b1;
    o_data = 8'h00;
  end

  task automatic send_byte(input logic sel, input logic [7:0] value);
    @(posedge i_core_clk);
    o_cmd_param_select <= sel;
    o_data <= value;
    repeat (PHASE) @(posedge i_core_clk);
    o_write_strobe_n <= 1'b0;
    repeat (PHASE) @(posedge i_core_clk);
    o_write_strobe_n <= 1'b1;
    repeat (PHASE) @(posedge i_core_clk);
    // Once the hold time is over the lines must not keep showing the byte.
    o_cmd_param_select <= ~sel;
    o_data <= ~value;
  endtask : send_byte

  // Command, then six bytes high byte first; callers keep the three counts summing to the panel height.
  task automatic define_layout(input logic [15:0] top, input logic [15:0] area, input logic [15:0] bottom);
    send_byte(1'b0, scat_pkg::CMD_SCROLL_REGION_DEFINE);
    send_byte(1'b1, top[15:8]);
    send_byte(1'b1, top[7:0]);
    send_byte(1'b1, area[15:8]);
    send_byte(1'b1, area[7:0]);
    send_byte(1'b1, bottom[15:8]);
    send_byte(1'b1, bottom[7:0]);
  endtask : define_layout

  // The start address is always chosen inside the scroll area; no exchange bit is ever written.
  task automatic start_scroll(input logic [15:0] addr);
    send_byte(1'b0, scat_pkg::CMD_SCROLL_START);
    send_byte(1'b1, addr[15:8]);
    send_byte(1'b1, addr[7:0]);
  endtask : start_scroll
endmodule : scat_host_model
`default_nettype wire

// [scat_ctrl_bench.sv]
// Self-checking testbench for the scroll-area and tear-control command logic.
`timescale 1ns/1ns
`default_nettype none
module scat_ctrl_bench;
  logic core_clk, reset, strobe_n, sel, order, tear_timing, mode, tear_en, tear_out;
  logic [7:0] data;
  logic [8:0] top, area, bottom, first, last;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  scat_host_model i_scat_host_model (.i_core_clk(core_clk), .o_write_strobe_n(strobe_n),
    .o_cmd_param_select(sel), .o_data(data));
  scat_ctrl i_scat_ctrl (.i_core_clk(core_clk), .i_reset(reset), .i_write_strobe_n(strobe_n),
    .i_cmd_param_select(sel), .i_data(data), .i_vertical_refresh_order(order), .i_tear_timing(tear_timing),
    .o_top_fixed_lines(top), .o_scroll_area_lines(area), .o_bottom_fixed_lines(bottom),
    .o_scroll_first_line(first), .o_scroll_last_line(last), .o_scroll_mode(mode),
    .o_tear_enabled(tear_en), .o_tear_sync_output(tear_out));

  // ==========================================================================
  // Reporting
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test();
    end
  end

  task automatic check_line(input logic [8:0] got, input logic [8:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_line

  task automatic check_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_flag

  task automatic check_layout(input logic [8:0] t, input logic [8:0] a, input logic [8:0] b);
    check_line(top, t, "top fixed");
    check_line(area, a, "scroll area");
    check_line(bottom, b, "bottom fixed");
  endtask : check_layout

  // ==========================================================================
  // Bus helpers
  task automatic cmd(input logic [7:0] c);
    i_scat_host_model.send_byte(1'b0, c);
  endtask : cmd

  task automatic param(input logic [7:0] p);
    i_scat_host_model.send_byte(1'b1, p);
  endtask : param

  // Register outputs follow a byte within two cycles of the bus returning the lines.
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle

  // ==========================================================================
  // Tests
  initial begin
    reset = 1'b1;
    order = 1'b0;
    tear_timing = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check_layout(9'h000, 9'h1e0, 9'h000);
    check_flag(tear_en, 1'b0, "tear enable after reset");
    check_flag(tear_out, 1'b0, "tear out after reset");
    cmd(scat_pkg::CMD_TEAR_SIGNAL_ENABLE);
    settle();
    check_flag(tear_out, 1'b1, "tear out enabled");
    @(posedge core_clk);
    tear_timing <= 1'b0;
    settle();
    check_flag(tear_out, 1'b0, "tear out with timing low");
    @(posedge core_clk);
    tear_timing <= 1'b1;
    settle();
    check_flag(tear_out, 1'b1, "tear out with timing high");
    param(scat_pkg::CMD_TEAR_SIGNAL_DISABLE);
    settle();
    check_flag(tear_en, 1'b1, "parameter taken as command");
    cmd(scat_pkg::CMD_TEAR_SIGNAL_DISABLE);
    settle();
    check_flag(tear_en, 1'b0, "tear disable");
    check_flag(tear_out, 1'b0, "tear out disabled");
    cmd(scat_pkg::CMD_TEAR_SIGNAL_DISABLE);
    settle();
    check_flag(tear_en, 1'b0, "second tear disable");
    check_layout(9'h000, 9'h1e0, 9'h000);
    cmd(scat_pkg::CMD_SCROLL_REGION_DEFINE);
    param(8'hfe);
    param(8'h10);
    param(8'h01);
    param(8'ha0);
    param(8'h00);
    settle();
    check_layout(9'h000, 9'h1e0, 9'h000);
    param(8'h30);
    settle();
    check_layout(9'h010, 9'h1a0, 9'h030);
    check_line(first, 9'h010, "first line order 0");
    check_line(last, 9'h1af, "last line order 0");
    @(posedge core_clk);
    order <= 1'b1;
    settle();
    check_line(first, 9'h030, "first line order 1");
    check_line(last, 9'h1cf, "last line order 1");
    cmd(scat_pkg::CMD_SCROLL_REGION_DEFINE);
    param(8'h00);
    param(8'h40);
    i_scat_host_model.start_scroll(16'h0100);
    param(8'h55);
    settle();
    check_layout(9'h010, 9'h1a0, 9'h030);
    check_flag(mode, 1'b1, "scroll mode entered");
    cmd(scat_pkg::CMD_NORMAL_DISPLAY);
    settle();
    check_flag(mode, 1'b0, "normal display leaves scroll");
    i_scat_host_model.start_scroll(16'h0050);
    #1;
    check_flag(mode, 1'b1, "scroll mode entered again");
    cmd(scat_pkg::CMD_PARTIAL_DISPLAY);
    settle();
    check_flag(mode, 1'b0, "partial display leaves scroll");
    i_scat_host_model.define_layout(16'h0020, 16'h01a0, 16'h0020);
    settle();
    check_layout(9'h020, 9'h1a0, 9'h020);
    cmd(scat_pkg::CMD_SOFT_RESET);
    settle();
    check_layout(9'h000, 9'h1e0, 9'h000);
    stop_test();
  end
endmodule : scat_ctrl_bench
`default_nettype wire
